// *** core/psr_cfg.svh ***
// Offsets, field positions, reset values for the port status block
// Assumes inclusion by the one design file, the package and the bench
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH
// ==================================================
// Register offsets (low 16 address bits)
`define PSR_OFF_STATUS   16'h1000
`define PSR_OFF_RELEASE  16'h1004
`define PSR_OFF_INIT     16'h1008
`define PSR_OFF_MAINT    16'h100c
`define PSR_OFF_CTRL     16'h1010
// ==================================================
// Status fields
`define PSR_B_SUMMARY    15
`define PSR_B_UNINIT     10
`define PSR_B_MIF        9
`define PSR_B_MAINT      8
`define PSR_NUM_EV       9
// Maintenance flags sit at bits 15:8, bus timeout at 8
`define PSR_MAINT_LSB    8
`define PSR_NUM_MAINT    8
// ==================================================
// Reset values
`define PSR_RST_UNINIT   1'b1
`define PSR_RST_MIE      1'b1
`endif

// *** core/psr_pkg.sv ***
// Types shared by the port status block
// Assumes psr_cfg.svh is on the include path
`include "psr_cfg.svh"
package psr_pkg;
    // ==================================================
    // Event strobes from the port engine, one cycle each
    typedef struct packed {
        logic misc_error;
        logic memory_fault;
        logic structure_fault;
        logic init_complete;
        logic disable_complete;
        logic free_queue_empty;
        logic resp_queue_avail;
    } psr_ev_t;
    // Timer strobes
    typedef struct packed {
        logic sanity_expired;
        logic boot_expired;
    } psr_tmr_t;
endpackage : psr_pkg

// *** core/psr_status.sv ***
// Port status and interrupt-cause register bank, AHB-Lite slave
// Assumes one clock hclk, events synchronous to it, single word
// transfers only
//
// What this block does
// R1 - Once interrupting, status bits freeze until release register gets one.
// R2 - Driver treats status as read-only, valid between interrupt and release.
// R3 - Driver must not write status; writes could fake interrupts.
// R4 - Bits 14:11 and 31:16 read zero.
// R5 - Bit 15 is OR of uninit, bits 8 down to 1.
// R6 - Bit 10 uninitialized; maintenance fault sets; init write or boot exits.
// R7 - Bit 9 sets on any interrupt cause; writes ignored.
// R8 - Hardware failure sets bit 8, uninit, halts microcode, interrupts.
// R9 - Any maintenance parity flag can set the maintenance fault bit.
// R10 - Maintenance fault during pending interrupt re-interrupts after release.
// R11 - Release clears interrupt, keeps maintenance flags.
// R12 - Bit 7 misc error, interrupts, port heads to disabled.
// R13 - Bit 6 on sanity or boot timer expiry.
// R14 - Bit 5 on memory system fault; port disabled.
// R15 - Bit 4 on data structure fault; port disabled.
// R16 - Bit 3 on init complete; port disabled.
// R17 - Bit 2 disable complete; queues and link traffic ignored.
// R18 - Bit 1 on empty free queue; processing continues.
// R19 - Bit 0 on insert to empty response queue.
// R20 - Each maintenance parity flag setting also sets maintenance fault.
// R21 - Interrupt stays asserted from latch until release write.
//
// Register access over AHB-Lite is this design's own decision.
`include "psr_cfg.svh"
module psr_status #(
    parameter int MAINT_W = `PSR_NUM_MAINT
) (
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic               hready,
    input  wire logic [31:0]        hwdata,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // Port engine events
    input  wire psr_pkg::psr_ev_t   ev,
    input  wire psr_pkg::psr_tmr_t  tmr,
    input  wire logic [MAINT_W-1:0] maint_err,
    input  wire logic               port_enabled,
    // Port control outputs
    output logic                    irq,
    output logic                    ucode_halt,
    output logic                    port_disabled,
    output logic                    link_ignore
);
    localparam int NE = `PSR_NUM_EV;

    // ==================================================
    // Status word assembly
    function automatic logic [31:0] make_view(
        input logic [NE-1:0] evb,
        input logic          uninitialized_flag,
        input logic          maint_interrupt_flag
    );
        logic [31:0] v;
        v = 32'h0000_0000; // [R4]
        v[NE-1:0] = evb;
        v[`PSR_B_MIF] = maint_interrupt_flag;
        v[`PSR_B_UNINIT] = uninitialized_flag;
        v[`PSR_B_SUMMARY] = uninitialized_flag | (|evb[NE-1:1]); // [R5]
        return v;
    endfunction : make_view

    // ==================================================
    // Bus address and data phase
    logic        dp_valid_q;
    logic        dp_write_q;
    logic [15:0] dp_addr_q;
    logic [31:0] hrdata_q;
    wire logic   ap_take = hsel & htrans[1] & hready;
    wire logic [15:0] ap_addr = haddr[15:0];

    wire logic dp_wr = dp_valid_q & dp_write_q;
    // Writes to the status word itself are dropped
    wire logic release_wr = dp_wr & (dp_addr_q == `PSR_OFF_RELEASE)
                            & hwdata[0]; // [R1] [R3] [R7]
    wire logic init_wr = dp_wr & (dp_addr_q == `PSR_OFF_INIT)
                         & hwdata[0];
    wire logic ctrl_wr = dp_wr & (dp_addr_q == `PSR_OFF_CTRL);

    // ==================================================
    // Maintenance flags and event vector
    logic [MAINT_W-1:0] mcs_q;
    logic [NE-1:0]      ev_q;
    logic [NE-1:0]      pend_q;
    logic               frozen_q;
    logic               uninitialized_flag_q;
    logic               shown_q;
    logic               mie_q;
    logic               halt_q;
    logic               dis_q;
    logic               link_ign_q;
    logic               irq_q;

    // Bit 0 of maint_err is the bus timeout, not a parity flag
    wire logic [MAINT_W-1:0] par_new = maint_err & ~mcs_q;
    wire logic mte_ev = |par_new[MAINT_W-1:1]; // [R9] [R20]
    // Flags clear on init, but a new error that cycle still lands
    wire logic [MAINT_W-1:0] mcs_d = init_wr ? maint_err
                                   : (mcs_q | maint_err); // [R11]

    wire logic [NE-1:0] evt = {
        mte_ev,                                        // [R8]
        ev.misc_error,                                 // [R12]
        tmr.sanity_expired | tmr.boot_expired,         // [R13]
        ev.memory_fault,                               // [R14]
        ev.structure_fault,                            // [R15]
        ev.init_complete,                              // [R16]
        ev.disable_complete,                           // [R17]
        ev.free_queue_empty,                           // [R18]
        ev.resp_queue_avail                            // [R19]
    };

    // Entering uninit wins over leaving it
    wire logic uninitialized_flag_d = (mte_ev | tmr.sanity_expired) ? 1'b1
                      : (init_wr | tmr.boot_expired) ? 1'b0
                      : uninitialized_flag_q; // [R6] [R8] [R13]
    wire logic halt_d = mte_ev | (halt_q & ~init_wr); // [R8]
    wire logic dis_set = |{ev.misc_error, ev.memory_fault,
                           ev.structure_fault, ev.init_complete,
                           ev.disable_complete};
    wire logic dis_d = dis_set | (dis_q & ~port_enabled); // [R14] [R17]
    wire logic mie_d = ctrl_wr ? hwdata[0] : mie_q;

    // A release reloads from whatever arrived while frozen
    wire logic [NE-1:0] merged = pend_q | evt;
    wire logic rearm = frozen_q & release_wr;
    wire logic frozen_d = frozen_q ? (release_wr ? |merged : 1'b1)
                                   : |evt; // [R10] [R21]

    wire logic [31:0] view = make_view(ev_q, shown_q, frozen_q);

    wire logic [31:0] rd_word =
        (ap_addr == `PSR_OFF_STATUS) ? view :
        (ap_addr == `PSR_OFF_MAINT)
            ? 32'({mcs_q, `PSR_MAINT_LSB'(0)}) :
        (ap_addr == `PSR_OFF_CTRL) ? {31'h0000_0000, mie_q} :
        32'h0000_0000;

    // ==================================================
    // Bus flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q  <= 16'h0000;
            hrdata_q   <= 32'h0000_0000;
        end else begin
            dp_valid_q <= ap_take;
            dp_write_q <= hwrite;
            dp_addr_q  <= ap_addr;
            if (ap_take && !hwrite) begin
                hrdata_q <= rd_word;
            end
        end
    end

    // ==================================================
    // Frozen status capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ev_q     <= '0;
            pend_q   <= '0;
            frozen_q <= 1'b0;
            shown_q  <= `PSR_RST_UNINIT;
        end else if (!frozen_q) begin
            ev_q     <= evt;
            pend_q   <= '0;
            frozen_q <= frozen_d;
            shown_q  <= uninitialized_flag_d;
        end else if (release_wr) begin
            ev_q     <= merged; // [R10]
            pend_q   <= '0;
            frozen_q <= frozen_d;
            shown_q  <= uninitialized_flag_d;
        end else begin
            pend_q   <= merged; // [R1]
        end
    end

    // ==================================================
    // Port state and outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mcs_q      <= '0;
            uninitialized_flag_q     <= `PSR_RST_UNINIT;
            mie_q      <= `PSR_RST_MIE;
            halt_q     <= 1'b0;
            dis_q      <= 1'b0;
            link_ign_q <= 1'b1;
            irq_q      <= 1'b0;
        end else begin
            mcs_q      <= mcs_d;
            uninitialized_flag_q     <= uninitialized_flag_d;
            mie_q      <= mie_d;
            halt_q     <= halt_d;
            dis_q      <= dis_d;
            link_ign_q <= uninitialized_flag_d | dis_d; // [R6] [R17]
            irq_q      <= frozen_d & mie_d; // [R21]
        end
    end

    assign hrdata        = hrdata_q;
    assign hreadyout     = dp_valid_q | 1'b1;
    assign hresp         = 1'b0;
    assign irq           = irq_q;
    assign ucode_halt    = halt_q;
    assign port_disabled = dis_q;
    assign link_ignore   = link_ign_q;

    // ==================================================
    // Checks
    property p_freeze;
        @(posedge hclk) disable iff (!hresetn)
        frozen_q && !release_wr |=> $stable(ev_q) && $stable(shown_q);
    endproperty
    a_freeze: assert property (p_freeze) // [R1]
        else $error("status changed while frozen");

    property p_rsvd;
        @(posedge hclk) disable iff (!hresetn)
        dp_valid_q && !dp_write_q && dp_addr_q == `PSR_OFF_STATUS
        |-> hrdata_q[31:16] == 16'h0000 && hrdata_q[14:11] == 4'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) // [R4]
        else $error("reserved status bits nonzero");

    property p_summary;
        @(posedge hclk) disable iff (!hresetn)
        (|ev_q[NE-1:1] || shown_q) |-> view[`PSR_B_SUMMARY];
    endproperty
    a_summary: assert property (p_summary) // [R5]
        else $error("summary bit missing");

    property p_mif;
        @(posedge hclk) disable iff (!hresetn)
        !frozen_q && (|evt) |=> frozen_q && view[`PSR_B_MIF] && ev_q != 0;
    endproperty
    a_mif: assert property (p_mif) // [R7]
        else $error("interrupt flag did not set");

    property p_halt;
        @(posedge hclk) disable iff (!hresetn)
        mte_ev |=> halt_q && uninitialized_flag_q && link_ign_q && frozen_q
        && irq_q == mie_q;
    endproperty
    a_halt: assert property (p_halt) // [R8]
        else $error("hardware failure not handled");

    property p_parity;
        @(posedge hclk) disable iff (!hresetn)
        |par_new[MAINT_W-1:1] |=> (ev_q[`PSR_B_MAINT] || pend_q[`PSR_B_MAINT]);
    endproperty
    a_parity: assert property (p_parity) // [R9]
        else $error("parity flag lost");

    property p_rearm;
        @(posedge hclk) disable iff (!hresetn)
        rearm && pend_q[`PSR_B_MAINT] |=> frozen_q && ev_q[`PSR_B_MAINT];
    endproperty
    a_rearm: assert property (p_rearm) // [R10]
        else $error("no new interrupt after release");

    property p_keep;
        @(posedge hclk) disable iff (!hresetn)
        release_wr && !init_wr |=> (($past(mcs_q) & ~mcs_q) == '0);
    endproperty
    a_keep: assert property (p_keep) // [R11]
        else $error("release cleared maintenance flags");

    property p_irq;
        @(posedge hclk) disable iff (!hresetn)
        frozen_q && !release_wr |=> frozen_q && irq_q == mie_q;
    endproperty
    a_irq: assert property (p_irq) // [R21]
        else $error("interrupt dropped before release");

    property p_dis;
        @(posedge hclk) disable iff (!hresetn)
        ev.structure_fault || ev.memory_fault |=> port_disabled;
    endproperty
    a_dis: assert property (p_dis) // [R14] [R15]
        else $error("port not disabled");

    property p_idle_port;
        @(posedge hclk) disable iff (!hresetn)
        ev.init_complete || ev.disable_complete
        |=> port_disabled && link_ignore;
    endproperty
    a_idle_port: assert property (p_idle_port) // [R16] [R17]
        else $error("port not disabled after init or disable");

    property p_sanity;
        @(posedge hclk) disable iff (!hresetn)
        tmr.sanity_expired |=> uninitialized_flag_q && link_ignore;
    endproperty
    a_sanity: assert property (p_sanity) // [R13]
        else $error("sanity expiry did not enter uninit");

    property p_uninitialized_flag_exit;
        @(posedge hclk) disable iff (!hresetn)
        init_wr && !mte_ev && !tmr.sanity_expired |=> !uninitialized_flag_q && !ucode_halt;
    endproperty
    a_uninitialized_flag_exit: assert property (p_uninitialized_flag_exit) // [R6]
        else $error("init write did not leave uninit");
endmodule : psr_status

// *** test/test_port_status_interrupt_register.sv ***
// Self-checking bench for the port status register bank
// Assumes psr_pkg and psr_status are compiled before this file
`include "psr_cfg.svh"
module test_port_status_interrupt_register;
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================
    // Signals
    logic              hclk;
    logic              hresetn;
    logic [31:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    psr_pkg::psr_ev_t  ev;
    psr_pkg::psr_tmr_t tmr;
    logic [7:0]        maint_err;
    logic              port_enabled;
    logic              irq;
    logic              ucode_halt;
    logic              port_disabled;
    logic              link_ignore;
    logic [31:0]       rd;
    logic [7:0]        lfsr;
    int                n_fail;
    int                num_checks;
    int                cyc;

    psr_status u_psr_status (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ev(ev), .tmr(tmr),
        .maint_err(maint_err), .port_enabled(port_enabled), .irq(irq),
        .ucode_halt(ucode_halt), .port_disabled(port_disabled),
        .link_ignore(link_ignore)
    );

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // ==================================================
    // Expectations
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nxt

    // Bit 6 gap: struct holds no event for status bit 6
    function automatic logic [31:0] exp_st(input logic [6:0] v,
                                           input logic un);
        logic [31:0] s;
        s = {24'h000000, v[6], 1'b0, v[5:0]};
        s[9] = (v != 7'h00);
        s[10] = un;
        s[15] = (v[6:1] != 6'h00) || un;
        return s;
    endfunction : exp_st

    // ==================================================
    // Compare, bus and stimulus tasks
    task automatic chk_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    // Holds each phase until hready is seen high
    task automatic bus(input logic wr, input logic [15:0] a,
                       input logic [31:0] wd);
        htrans <= 2'h2;
        haddr <= {16'h0000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic rd_st(input logic [31:0] e, input logic ei);
        bus(1'b0, `PSR_OFF_STATUS, 32'h00000000);
        chk_word("status", e, rd);
        chk_bit("irq", ei, irq);
        chk_bit("hresp", 1'b0, hresp);
    endtask : rd_st

    task automatic rel;
        bus(1'b1, `PSR_OFF_RELEASE, 32'h00000001);
    endtask : rel

    task automatic pulse(input logic [6:0] v, input logic [1:0] t,
                         input logic [7:0] m);
        ev <= v;
        tmr <= t;
        maint_err <= m;
        @(posedge hclk);
        ev <= 7'h00;
        tmr <= 2'h0;
        maint_err <= 8'h00;
        @(posedge hclk);
    endtask : pulse

    task automatic summarize;
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // Whole run is about two hundred cycles; this only catches a hang
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end

    // ==================================================
    // Main sequence
    initial begin
        hresetn = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ev = 7'h00;
        tmr = 2'h0;
        maint_err = 8'h00;
        port_enabled = 1'b0;
        n_fail = 0;
        num_checks = 0;
        cyc = 0;
        lfsr = 8'h30;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_st(32'h00008400, 1'b0);
        chk_bit("link_ignore", 1'b1, link_ignore);
        bus(1'b1, `PSR_OFF_STATUS, 32'hffffffff);
        rd_st(32'h00008400, 1'b0);
        bus(1'b0, 16'h1020, 32'h0);
        chk_word("unmapped", 32'h0, rd);
        bus(1'b1, `PSR_OFF_INIT, 32'h00000001);
        rd_st(32'h0, 1'b0);
        chk_bit("link_ignore", 1'b0, link_ignore);
        for (int i = 0; i < 7; i++) begin
            pulse(7'h01 << i, 2'h0, 8'h00);
            rd_st(exp_st(7'h01 << i, 1'b0), 1'b1);
            rel();
            rd_st(32'h0, 1'b0);
        end
        chk_bit("port_disabled", 1'b1, port_disabled);
        port_enabled <= 1'b1;
        @(posedge hclk);
        port_enabled <= 1'b0;
        @(posedge hclk);
        @(posedge hclk);
        chk_bit("port_disabled", 1'b0, port_disabled);
        repeat (8) begin
            lfsr = nxt(lfsr);
            pulse(lfsr[6:0] | 7'h01, 2'h0, 8'h00);
            rd_st(exp_st(lfsr[6:0] | 7'h01, 1'b0), 1'b1);
            rel();
            rd_st(32'h0, 1'b0);
        end
        // Later events and a fault must stay hidden while frozen
        pulse(7'h08, 2'h0, 8'h00);
        pulse(7'h02, 2'h0, 8'h00);
        rd_st(32'h00008208, 1'b1);
        pulse(7'h00, 2'h0, 8'h02);
        bus(1'b0, `PSR_OFF_STATUS, 32'h0);
        chk_word("frozen", 32'h00008208, rd);
        rel();
        rd_st(32'h00008702, 1'b1);
        chk_bit("ucode_halt", 1'b1, ucode_halt);
        rel();
        bus(1'b0, `PSR_OFF_MAINT, 32'h0);
        chk_word("maint", 32'h00000200, rd & 32'h0000ff00);
        chk_bit("irq", 1'b0, irq);
        bus(1'b1, `PSR_OFF_INIT, 32'h00000001);
        rd_st(32'h0, 1'b0);
        chk_bit("ucode_halt", 1'b0, ucode_halt);
        // Bus timeout flag is recorded but is no maintenance fault
        pulse(7'h00, 2'h0, 8'h01);
        rd_st(32'h0, 1'b0);
        bus(1'b0, `PSR_OFF_MAINT, 32'h0);
        chk_word("maint", 32'h00000100, rd);
        pulse(7'h00, 2'h2, 8'h00);
        rd_st(32'h00008640, 1'b1);
        rel();
        rd_st(32'h00008400, 1'b0);
        pulse(7'h00, 2'h1, 8'h00);
        rd_st(32'h00008240, 1'b1);
        rel();
        rd_st(32'h0, 1'b0);
        // Polled mode: flag sets with the request held off
        bus(1'b0, `PSR_OFF_CTRL, 32'h0);
        chk_word("ctrl", 32'h00000001, rd);
        bus(1'b1, `PSR_OFF_CTRL, 32'h0);
        bus(1'b0, `PSR_OFF_CTRL, 32'h0);
        chk_word("ctrl", 32'h0, rd);
        pulse(7'h01, 2'h0, 8'h00);
        rd_st(32'h00000201, 1'b0);
        rel();
        bus(1'b1, `PSR_OFF_CTRL, 32'h00000001);
        rd_st(32'h0, 1'b0);
        summarize();
    end
endmodule : test_port_status_interrupt_register
